//--- bench/mhfra_setup_host.sv
module mhfra_setup_host
(
  // Clock
  input  wire logic        clk,
  // Control
  input  wire logic        start,
  output logic             busy,
  // Setup stream
  output logic             setupValid,
  input  wire logic        setupReady,
  output logic      [31:0] setupWord,
  output logic             setupLast
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [31:0] frame [35];
  int          idx;
  logic        took;
  logic        go;

  initial
  begin
    busy = 1'b0;
    setupValid = 1'b0;
    setupWord = 32'h0;
    setupLast = 1'b0;
    idx = 0;
  end

  always @(posedge clk)
    took <= setupValid & setupReady;

  // Start request sampled on the rising edge, clear of the bench's falling-edge drive
  always @(posedge clk)
    go <= start;

  // Word held until taken; released bus shows inverted value
  always @(negedge clk)
  begin
    if (setupValid && took)
    begin
      if (idx == 34)
      begin
        setupValid <= 1'b0;
        setupLast <= 1'b0;
        setupWord <= ~setupWord;
        busy <= 1'b0;
      end
      else
      begin
        setupWord <= frame[idx + 1];
        setupLast <= (idx == 33);
        idx <= idx + 1;
      end
    end
    else if (go && !busy)
    begin
      busy <= 1'b1;
      idx <= 0;
      setupValid <= 1'b1;
      setupWord <= frame[0];
    end
  end
endmodule : mhfra_setup_host

//--- bench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int RS = 8;
  localparam int HOLD = 50;
  logic        clk, reset, hwResetN, busModeWrite, cfgWrite, rxStart, txStart;
  logic [31:0] busModeData, operatingMode, cfgData, cfgValue, setupWord;
  logic        deviceReady, rxRunning, txRunning, descWb, setupValid, setupReady;
  logic        setupLast, destValid, filterDone, filterAccept, perfectLookup;
  logic        start, busy, transmitActive, rxPacketEnd, txPacketEnd, burstDone;
  logic        grantRx, grantTx;
  logic [47:0] destAddr, stationAddr;
  logic [3:0]  txReq, rxReq;
  logic [11:0] rxFree, txFree, thr;
  int          errTotal, checkCount;

  mhfra_mac_filter_arbiter #(.RESET_SEQ(RS)) dut
  (
    .clk, .reset, .hwResetN, .busModeWrite, .busModeData, .operatingMode,
    .rxStart, .txStart, .cfgWrite, .cfgData, .cfgValue, .deviceReady,
    .rxRunning, .txRunning, .descWritebackEnable(descWb), .setupValid,
    .setupReady, .setupWord, .setupLast, .destValid, .destAddr, .filterDone,
    .filterAccept, .perfectLookup, .stationAddr, .txDescFetch(txReq[0]),
    .txDescClose(txReq[1]), .txSetupProcess(txReq[2]), .txBurstSpace(txReq[3]),
    .rxDescFetch(rxReq[0]), .rxDescClose(rxReq[1]), .rxBurstData(rxReq[2]),
    .rxShortEnd(rxReq[3]), .transmitActive, .rxFreeBytes(rxFree),
    .txFreeBytes(txFree), .rxPacketEnd, .txPacketEnd, .burstDone, .grantRx, .grantTx
  );

  mhfra_setup_host src
  (
    .clk, .start, .busy, .setupValid, .setupReady, .setupWord, .setupLast
  );

  always #25 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic nc(input int n);
    repeat (n) @(negedge clk);
  endtask : nc

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checkCount++;
    if (got !== exp)
    begin
      errTotal++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic testDone;
    $display("checks=%0d errors=%0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : testDone

  function automatic logic [8:0] hidx(input logic [47:0] a);
    logic [31:0] c;
    c = mhfra_pkg::CRC_INIT;
    for (int i = 0; i < 48; i++)
      c = {c[30:0], 1'b0} ^ ((c[31] ^ a[i]) ? mhfra_pkg::CRC_POLY : 32'h0);
    return c[31:23];
  endfunction : hidx

  task automatic waitReady(output int n);
    n = 0;
    while (deviceReady !== 1'b1 && n < 100)
    begin
      nc(1);
      n++;
    end
  endtask : waitReady

  task automatic busWrite(input logic [31:0] d);
    busModeData = d;
    busModeWrite = 1'b1;
    nc(1);
    busModeWrite = 1'b0;
  endtask : busWrite

  ////////////////////////////////////////////////////////////////////////////
  task automatic testReset;
    int n;
    waitReady(n);
    chk(n >= RS - 2 && n <= RS + 8, 1);
    chk({rxRunning, txRunning}, 0);
    nc(HOLD - n);
    rxStart = 1'b1;
    cfgData = 32'h5a5a1234;
    cfgWrite = 1'b1;
    nc(1);
    cfgWrite = 1'b0;
    nc(1);
    chk(rxRunning, 1);
    busWrite(32'h1);
    nc(1);
    chk({deviceReady, rxRunning, descWb}, 0);
    chk(cfgValue, 32'h5a5a1234);
    // Pin reset while the software sequence still runs
    hwResetN = 1'b0;
    nc(2);
    hwResetN = 1'b1;
    waitReady(n);
    chk(n >= RS, 1);
    chk({deviceReady, cfgValue}, {1'b1, 32'h0});
    nc(HOLD);
    busWrite(32'h2);
    $display("reset test done");
  endtask : testReset

  task automatic look(input logic [47:0] a, input logic acc, input logic hm);
    destAddr = a;
    destValid = 1'b1;
    nc(1);
    chk({filterDone, perfectLookup}, {hm, !hm});
    if (hm)
      chk(filterAccept, acc);
    destValid = 1'b0;
    nc(1);
  endtask : look

  task automatic testFilter;
    logic [47:0] mc, mc2, st;
    logic [8:0]  ia;
    mc = 48'h0027_0025_0025;
    mc2 = 48'h8725_3f62_c5a3;
    st = 48'h0876_3534_12a8;
    ia = hidx(mc);
    for (int k = 0; k < 35; k++)
      src.frame[k] = 32'hffff0000;
    src.frame[ia[8:4]][ia[3:0]] = 1'b1;
    src.frame[32][15:0] = st[15:0];
    src.frame[33][15:0] = st[31:16];
    src.frame[34][15:0] = st[47:32];
    operatingMode = 32'h1;
    start = 1'b1;
    nc(1);
    start = 1'b0;
    nc(1);
    destValid = 1'b1;
    nc(5);
    chk(setupReady, 0);
    destValid = 1'b0;
    for (int k = 0; k < 200 && busy === 1'b1; k++)
      nc(1);
    nc(4);
    chk(stationAddr, st);
    look(mc, 1, 1);
    look(mc2, hidx(mc2) == ia, 1);
    look(st, 1, 1);
    look(st ^ 48'h100, 0, 1);
    operatingMode = 32'h0;
    look(mc, 0, 0);
    $display("filter test done");
  endtask : testFilter

  // Stat bits: transmit active, rx free above, tx free above
  task automatic arb(input logic [3:0] t, input logic [3:0] r, input logic [2:0] s, input logic expRx);
    transmitActive = s[2];
    rxFree = s[1] ? thr + 12'h001 : thr;
    txFree = s[0] ? thr + 12'h001 : thr;
    txReq = t;
    rxReq = r;
    for (int k = 0; k < 10 && !(grantRx | grantTx); k++)
      nc(1);
    chk({grantRx, grantTx}, {expRx, !expRx});
    txReq = 4'h0;
    rxReq = 4'h0;
    burstDone = 1'b1;
    nc(1);
    burstDone = 1'b0;
    nc(2);
    chk({grantRx, grantTx}, 0);
  endtask : arb

  task automatic testArb;
    for (int k = 0; k < 4; k++)
    begin
      arb(4'h1 << k, 4'h0, 3'b000, 0);
      arb(4'h0, 4'h1 << k, 3'b111, 1);
    end
    arb(4'h1, 4'h1, 3'b000, 1);
    for (int k = 0; k < 3; k++)
      arb(4'h8, 4'h4, 3'(4 + k), 0);
    arb(4'h8, 4'h4, 3'b111, 1);
    for (int c = 1; c < 4; c++)
    begin
      operatingMode = 32'(c) << mhfra_pkg::OP_MODE_THRESHOLD_LSB;
      thr = (c == 1) ? mhfra_pkg::FREE_THRESH_1 : (c == 2) ? mhfra_pkg::FREE_THRESH_2 : mhfra_pkg::FREE_THRESH_3;
      arb(4'h8, 4'h4, 3'b111, 1);
      arb(4'h8, 4'h4, 3'b101, 0);
    end
    operatingMode = 32'h0;
    thr = mhfra_pkg::FREE_THRESH_0;
    rxPacketEnd = 1'b1;
    nc(1);
    rxPacketEnd = 1'b0;
    arb(4'h1, 4'h1, 3'b000, 0);
    txPacketEnd = 1'b1;
    nc(1);
    txPacketEnd = 1'b0;
    arb(4'h1, 4'h1, 3'b100, 1);
    transmitActive = 1'b1;
    rxFree = 12'hfff;
    txFree = 12'hfff;
    nc(4);
    chk({grantRx, grantTx}, 0);
    busWrite(32'h0);
    arb(4'h1, 4'h1, 3'b000, 0);
    $display("arbiter test done");
  endtask : testArb

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {clk, hwResetN, reset} = 3'b011;
    {busModeWrite, cfgWrite, rxStart, txStart, destValid, start} = 6'h0;
    {transmitActive, rxPacketEnd, txPacketEnd, burstDone} = 4'h0;
    {busModeData, operatingMode, cfgData} = 96'h0;
    {destAddr, txReq, rxReq, rxFree, txFree} = 80'h0;
    thr = mhfra_pkg::FREE_THRESH_0;
    errTotal = 0;
    checkCount = 0;
    nc(2);
    reset = 1'b0;
    testReset();
    testFilter();
    testArb();
    testDone();
  end

  initial
  begin
    #(50 * 5000);
    errTotal++;
    testDone();
  end
endmodule : testbench

//--- rtl/mhfra_buffer.sv
module mhfra_buffer #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr_q;
  logic [PW-1:0]    rdPtr_q;
  logic [PW:0]      count_q;
  logic             push;
  logic             pop;

  assign inReady  = (count_q != (PW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;
  assign outData  = mem[rdPtr_q];

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
        wrPtr_q <= (wrPtr_q == PW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
      if (pop)
        rdPtr_q <= (rdPtr_q == PW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
      count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule : mhfra_buffer

//--- rtl/mhfra_mac_filter_arbiter.sv
// Functional notes
// - Hash filtering when mode bit set, perfect otherwise
// - Hold 512-bit hash table, one station address
// - Multicast via hash, individual via station compare
// - CRC over six address bytes, top nine bits
// - Accept if indexed hash bit one
// - Hash bits numbered low-first across longwords
// - First byte lsb marks multicast
// - Reset from hardware pin or software bit
// - Any reset clears state except configuration registers, which only hardware reset clears, and the pin synchronizer, cleared only by the reset input
// - Software reset keeps configuration registers
// - No descriptor write-back during reset
// - After sequence, accept commands, processes stopped
// - New reset restarts sequence in progress
// - Receive precedence scheme selected by bit one
// - Transmit request sources incl. burst space
// - Receive request sources incl. short end
// - Lone requester wins; idle wire favours receive only with bit one set
// - During transmit, receive only if both above
// - Transmit gets burst between receive packets
// - Receive gets burst between transmit packets
module mhfra_mac_filter_arbiter #(
  parameter int FREE_W     = 12,
  parameter int RESET_SEQ  = mhfra_pkg::RESET_SEQ_CYCLES
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              hwResetN,
  // Mode words from the host
  input  wire logic              busModeWrite,
  input  wire logic [31:0]       busModeData,
  input  wire logic [31:0]       operatingMode,
  input  wire logic              rxStart,
  input  wire logic              txStart,
  // Configuration space
  input  wire logic              cfgWrite,
  input  wire logic [31:0]       cfgData,
  output logic      [31:0]       cfgValue,
  // Reset status
  output logic                   deviceReady,
  output logic                   rxRunning,
  output logic                   txRunning,
  output logic                   descWritebackEnable,
  // Setup frame longwords
  input  wire logic              setupValid,
  output logic                   setupReady,
  input  wire logic [31:0]       setupWord,
  input  wire logic              setupLast,
  // Destination address lookup
  input  wire logic              destValid,
  input  wire logic [47:0]       destAddr,
  output logic                   filterDone,
  output logic                   filterAccept,
  output logic                   perfectLookup,
  output logic      [47:0]       stationAddr,
  // Transmit request sources
  input  wire logic              txDescFetch,
  input  wire logic              txDescClose,
  input  wire logic              txSetupProcess,
  input  wire logic              txBurstSpace,
  // Receive request sources
  input  wire logic              rxDescFetch,
  input  wire logic              rxDescClose,
  input  wire logic              rxBurstData,
  input  wire logic              rxShortEnd,
  // Datapath status
  input  wire logic              transmitActive,
  input  wire logic [FREE_W-1:0] rxFreeBytes,
  input  wire logic [FREE_W-1:0] txFreeBytes,
  input  wire logic              rxPacketEnd,
  input  wire logic              txPacketEnd,
  input  wire logic              burstDone,
  // Grants
  output logic                   grantRx,
  output logic                   grantTx
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset pin sync and reset sequence

  logic        pinS1_q;
  logic        pinS2_q;
  logic        pinS3_q;
  logic        pinLow_q;
  logic        hwReset;
  logic        swReset;
  logic        sysReset;
  logic [15:0] seqCnt_q;
  logic        ready_q;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pinS1_q <= 1'b1;
      pinS2_q <= 1'b1;
      pinS3_q <= 1'b1;
    end
    else
    begin
      pinS1_q <= hwResetN;
      pinS2_q <= pinS1_q;
      pinS3_q <= pinS2_q;
    end
  end

  // Pin level taken only once the last two stages agree
  always_ff @(posedge clk)
  begin
    if (reset)
      pinLow_q <= 1'b0;
    else if (pinS2_q == pinS3_q)
      pinLow_q <= ~pinS2_q;
  end

  assign hwReset  = reset | pinLow_q;
  assign swReset  = busModeWrite & busModeData[mhfra_pkg::BUS_MODE_SW_RESET_BIT];
  assign sysReset = hwReset | swReset;

  // Each new reset restarts the count
  always_ff @(posedge clk)
  begin
    if (sysReset)
    begin
      seqCnt_q <= '0;
      ready_q  <= 1'b0;
    end
    else if (!ready_q)
    begin
      seqCnt_q <= seqCnt_q + 16'h0001;
      ready_q  <= (seqCnt_q == 16'(RESET_SEQ - 1));
    end
  end

  assign deviceReady         = ready_q;
  assign descWritebackEnable = ready_q;

  always_ff @(posedge clk)
  begin
    if (sysReset | ~ready_q)
    begin
      rxRunning <= 1'b0;
      txRunning <= 1'b0;
    end
    else
    begin
      rxRunning <= rxStart;
      txRunning <= txStart;
    end
  end

  // Only hardware reset touches configuration space
  always_ff @(posedge clk)
  begin
    if (hwReset)
      cfgValue <= '0;
    else if (cfgWrite)
      cfgValue <= cfgData;
  end

  logic rxPriority_q;

  always_ff @(posedge clk)
  begin
    if (sysReset)
      rxPriority_q <= 1'b0;
    else if (busModeWrite)
      rxPriority_q <= busModeData[mhfra_pkg::BUS_MODE_RX_PRIORITY_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Setup frame load

  logic        bufValid;
  logic        bufReady;
  logic [32:0] bufData;
  logic        lookupBusy_q;
  logic [5:0]  wordIdx_q;
  logic [mhfra_pkg::HASH_TABLE_BITS-1:0] hashTable_q;

  mhfra_buffer #(
    .WIDTH (33),
    .DEPTH (2)
  ) u_setup_buffer (
    .clk      (clk),
    .reset    (sysReset),
    .inValid  (setupValid),
    .inReady  (setupReady),
    .inData   ({setupLast, setupWord}),
    .outValid (bufValid),
    .outReady (bufReady),
    .outData  (bufData)
  );

  // Loading stalls while a lookup reads the table
  assign bufReady = ~lookupBusy_q & ~destValid;

  always_ff @(posedge clk)
  begin
    if (sysReset)
      wordIdx_q <= '0;
    else if (bufValid & bufReady)
      wordIdx_q <= bufData[32] ? '0 : wordIdx_q + 6'h01;
  end

  genvar w;
  generate
    for (w = 0; w < mhfra_pkg::HASH_TABLE_WORDS; w++)
    begin : g_hash_word
      always_ff @(posedge clk)
      begin
        if (sysReset)
          hashTable_q[w*16 +: 16] <= '0;
        else if (bufValid & bufReady & (wordIdx_q == 6'(w)))
          hashTable_q[w*16 +: 16] <= bufData[15:0];
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (sysReset)
      stationAddr <= '0;
    else if (bufValid & bufReady)
    begin
      if (wordIdx_q == 6'(mhfra_pkg::HASH_TABLE_WORDS))
        stationAddr[15:0] <= bufData[15:0];
      else if (wordIdx_q == 6'(mhfra_pkg::HASH_TABLE_WORDS + 1))
        stationAddr[31:16] <= bufData[15:0];
      else if (wordIdx_q == 6'(mhfra_pkg::HASH_TABLE_WORDS + 2))
        stationAddr[47:32] <= bufData[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address filter

  function automatic logic [31:0] crcOf(input logic [47:0] addr);
    logic [31:0] c;
    logic        fb;
    c = mhfra_pkg::CRC_INIT;
    for (int i = 0; i < mhfra_pkg::DEST_ADDR_BITS; i++)
    begin
      fb = c[31] ^ addr[i];
      c  = {c[30:0], 1'b0} ^ (fb ? mhfra_pkg::CRC_POLY : 32'h00000000);
    end
    return c;
  endfunction : crcOf

  logic        hashMode;
  logic        isMulticast;
  logic [31:0] crcValue;
  logic [8:0]  hashIndex;

  assign hashMode    = operatingMode[mhfra_pkg::OP_MODE_HASH_FILTER_BIT];
  assign isMulticast = destAddr[0];
  assign crcValue    = crcOf(destAddr);
  assign hashIndex   = crcValue[31:23];

  always_ff @(posedge clk)
  begin
    if (sysReset | ~ready_q)
    begin
      filterDone    <= 1'b0;
      filterAccept  <= 1'b0;
      perfectLookup <= 1'b0;
      lookupBusy_q  <= 1'b0;
    end
    else
    begin
      lookupBusy_q  <= destValid;
      filterDone    <= destValid & hashMode;
      perfectLookup <= destValid & ~hashMode;
      if (destValid & hashMode)
        filterAccept <= isMulticast ? hashTable_q[hashIndex]
                                    : (destAddr == stationAddr);
      else
        filterAccept <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // DMA arbiter

  logic [11:0] freeThresh;
  logic        rxAbove;
  logic        txAbove;
  logic        txReq;
  logic        rxReq;
  logic        pickRx;
  logic        txOwed_q;
  logic        rxOwed_q;
  mhfra_pkg::mhfra_arb_state_t arb_q;

  always_comb
  begin
    case (operatingMode[mhfra_pkg::OP_MODE_THRESHOLD_MSB:mhfra_pkg::OP_MODE_THRESHOLD_LSB])
      2'h0:    freeThresh = mhfra_pkg::FREE_THRESH_0;
      2'h1:    freeThresh = mhfra_pkg::FREE_THRESH_1;
      2'h2:    freeThresh = mhfra_pkg::FREE_THRESH_2;
      default: freeThresh = mhfra_pkg::FREE_THRESH_3;
    endcase
  end

  assign rxAbove = (12'(rxFreeBytes) > freeThresh);
  assign txAbove = (12'(txFreeBytes) > freeThresh);
  assign txReq   = txDescFetch | txDescClose | txSetupProcess | txBurstSpace;
  assign rxReq   = rxDescFetch | rxDescClose | rxBurstData | rxShortEnd;

  always_comb
  begin
    if (txOwed_q & txReq)
      pickRx = 1'b0;
    else if (rxOwed_q & rxReq)
      pickRx = 1'b1;
    else if (!txReq)
      pickRx = 1'b1;
    else if (!rxReq)
      pickRx = 1'b0;
    else if (!rxPriority_q)
      pickRx = 1'b0;
    else if (!transmitActive)
      pickRx = 1'b1;
    else
      pickRx = rxAbove & txAbove;
  end

  // Packet-boundary windows; a new packet end wins over the clear
  always_ff @(posedge clk)
  begin
    if (sysReset)
    begin
      txOwed_q <= 1'b0;
      rxOwed_q <= 1'b0;
    end
    else
    begin
      if (rxPacketEnd)
        txOwed_q <= 1'b1;
      else if ((arb_q == mhfra_pkg::ARB_TX) & burstDone)
        txOwed_q <= 1'b0;
      if (txPacketEnd)
        rxOwed_q <= 1'b1;
      else if ((arb_q == mhfra_pkg::ARB_RX) & burstDone)
        rxOwed_q <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sysReset | ~ready_q)
      arb_q <= mhfra_pkg::ARB_IDLE;
    else
    begin
      case (arb_q)
        mhfra_pkg::ARB_IDLE:
        begin
          if (txReq | rxReq)
            arb_q <= pickRx ? mhfra_pkg::ARB_RX : mhfra_pkg::ARB_TX;
        end
        mhfra_pkg::ARB_RX,
        mhfra_pkg::ARB_TX:
        begin
          if (burstDone)
            arb_q <= mhfra_pkg::ARB_IDLE;
        end
        default:
          arb_q <= mhfra_pkg::ARB_IDLE;
      endcase
    end
  end

  assign grantRx = (arb_q == mhfra_pkg::ARB_RX);
  assign grantTx = (arb_q == mhfra_pkg::ARB_TX);

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_idle_no_grant: assert property (@(posedge clk) disable iff (reset)
    ((arb_q == mhfra_pkg::ARB_IDLE) & ~txReq & ~rxReq) |=> ~grantRx & ~grantTx)
    else $error("grant issued without request");

  chk_lone_rx_grant: assert property (@(posedge clk) disable iff (sysReset)
    ((arb_q == mhfra_pkg::ARB_IDLE) & ready_q & rxReq & ~txReq & ~rxOwed_q & ~txOwed_q) |=> grantRx)
    else $error("lone receive request not granted");

  chk_busy_rx_thresh: assert property (@(posedge clk) disable iff (sysReset)
    ((arb_q == mhfra_pkg::ARB_IDLE) & ready_q & rxReq & txReq & transmitActive & rxPriority_q
     & ~txOwed_q & ~rxOwed_q & ~(rxAbove & txAbove)) |=> grantTx)
    else $error("receive granted below threshold");

  chk_tx_window: assert property (@(posedge clk) disable iff (sysReset)
    ((arb_q == mhfra_pkg::ARB_IDLE) & ready_q & txOwed_q & txReq) |=> grantTx)
    else $error("transmit window after receive packet missed");

  chk_rx_window: assert property (@(posedge clk) disable iff (sysReset)
    ((arb_q == mhfra_pkg::ARB_IDLE) & ready_q & rxOwed_q & rxReq & ~txOwed_q) |=> grantRx)
    else $error("receive window after transmit packet missed");

  chk_seq_length: assert property (@(posedge clk) disable iff (reset)
    sysReset ##1 (~sysReset)[*8] |-> ~ready_q)
    else $error("reset sequence ended too early");

  chk_stopped_after: assert property (@(posedge clk) disable iff (reset)
    $rose(ready_q) |-> ~rxRunning & ~txRunning)
    else $error("process running when reset sequence ends");

  chk_sw_keeps_cfg: assert property (@(posedge clk) disable iff (reset)
    (swReset & ~hwReset & ~cfgWrite) |=> (cfgValue == $past(cfgValue)))
    else $error("software reset altered configuration");

  chk_hash_accept: assert property (@(posedge clk) disable iff (sysReset)
    (ready_q & destValid & hashMode & destAddr[0])
    |=> (filterDone & (filterAccept == $past(hashTable_q[hashIndex]))))
    else $error("hash decision does not follow table bit");

  chk_no_writeback: assert property (@(posedge clk) disable iff (reset)
    sysReset |=> ~descWritebackEnable)
    else $error("write-back enabled during reset");

endmodule : mhfra_mac_filter_arbiter

//--- rtl/mhfra_pkg.sv
package mhfra_pkg;

  // Field positions of the host-written mode words
  localparam int BUS_MODE_SW_RESET_BIT    = 0;
  localparam int BUS_MODE_RX_PRIORITY_BIT = 1;
  localparam int OP_MODE_HASH_FILTER_BIT  = 0;
  localparam int OP_MODE_THRESHOLD_LSB    = 14;
  localparam int OP_MODE_THRESHOLD_MSB    = 15;

  // Imperfect filter setup frame layout, in longwords
  localparam int HASH_TABLE_BITS     = 512;
  localparam int HASH_BITS_PER_WORD  = 16;
  localparam int HASH_TABLE_WORDS    = HASH_TABLE_BITS / HASH_BITS_PER_WORD;
  localparam int STATION_ADDR_WORDS  = 3;
  localparam int SETUP_USED_WORDS    = HASH_TABLE_WORDS + STATION_ADDR_WORDS;
  localparam int HASH_INDEX_BITS     = 9;
  localparam int DEST_ADDR_BITS      = 48;

  // Ethernet CRC
  localparam logic [31:0] CRC_POLY = 32'h04c11db7;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;

  // Reset sequence length
  localparam int RESET_SEQ_CYCLES = 50;

  // Free-space threshold per two-bit code, in bytes
  localparam logic [11:0] FREE_THRESH_0 = 12'h080;
  localparam logic [11:0] FREE_THRESH_1 = 12'h100;
  localparam logic [11:0] FREE_THRESH_2 = 12'h200;
  localparam logic [11:0] FREE_THRESH_3 = 12'h400;

  // Arbiter states
  typedef enum logic [2:0]
  {
    ARB_IDLE = 3'b001,
    ARB_RX   = 3'b010,
    ARB_TX   = 3'b100
  } mhfra_arb_state_t;

endpackage : mhfra_pkg
